// File: dprc_busy_ctl.sv
// Holds the busy pin handling of one controlled port.
// Assumes busy_in_n carries each device's busy pin of a depth-expanded array.
`timescale 1ns/1ns
`default_nettype none
module dprc_busy_ctl #(
	parameter int N_BUSY = 1
) (
	// Configuration.
	input wire logic master_role,
	input wire logic block_writes,
	// Device busy pins.
	input wire logic [N_BUSY-1:0] busy_in_n,
	output logic busy_out_n,
	output logic busy_oe,
	output logic arbiter_role,
	// Result to the sequencer.
	output logic busy_ok
);

	// Role pin selects master arbitration or slave write-inhibit input.
	assign arbiter_role = master_role;

	// As a slave the pin is ours: high lets writes pass, low blocks them.
	// As a master the device drives both busy pins, so this side lets go.
	assign busy_oe = ~master_role;
	assign busy_out_n = ~block_writes;

	// Array busy is the AND of all device busy outputs in master role.
	assign busy_ok = master_role ? (&busy_in_n) : ~block_writes;

endmodule
`default_nettype wire

// File: dprc_consts.svh
// Holds the named constants of the dual-port RAM port controller.
// Assumes a 100 MHz pclk and one device port driven by this controller.
`ifndef DPRC_CONSTS_SVH
`define DPRC_CONSTS_SVH

// Clock period and the pin timing that the sequencer keeps.
`define DPRC_CLK_NS 10
`define DPRC_T_SETTLE_NS 20
`define DPRC_T_WRITE_NS 50
`define DPRC_T_READ_NS 70
`define DPRC_T_RECOVER_NS 20
`define DPRC_CYC(ns) (((ns) + `DPRC_CLK_NS - 1) / `DPRC_CLK_NS)

// Mailbox locations and semaphore space.
`define DPRC_MBOX_LEFT 14'h3ffe
`define DPRC_MBOX_RIGHT 14'h3fff
`define DPRC_SEM_LAST 3'h7
`define DPRC_SEM_FREE 8'hff
`define DPRC_SEM_TAKE 8'h00

// Register offsets.
`define DPRC_REG_CTRL 8'h00
`define DPRC_REG_ADDR 8'h04
`define DPRC_REG_WDATA 8'h08
`define DPRC_REG_RDATA 8'h0c
`define DPRC_REG_STATUS 8'h10
`define DPRC_REG_CFG 8'h14

// Field positions.
`define DPRC_CTRL_GO 0
`define DPRC_CTRL_CMD_LSB 1
`define DPRC_CTRL_CMD_MSB 3
`define DPRC_ST_ACTIVE 0
`define DPRC_ST_DONE 1
`define DPRC_ST_BUSY_SEEN 2
`define DPRC_ST_MBOX 3
`define DPRC_ST_OWNED 4
`define DPRC_ST_INIT_DONE 5
`define DPRC_ST_BUSY_OK 6
`define DPRC_ST_REFUSED 7
`define DPRC_CFG_MASTER 0
`define DPRC_CFG_BLOCK 1

// Command codes.
`define DPRC_CMD_MEM_RD 3'h0
`define DPRC_CMD_MEM_WR 3'h1
`define DPRC_CMD_SEM_RD 3'h2
`define DPRC_CMD_SEM_WR 3'h3
`define DPRC_CMD_SEM_ACQ 3'h4
`define DPRC_CMD_SEM_REL 3'h5
`define DPRC_CMD_MBOX_SEND 3'h6
`define DPRC_CMD_MBOX_TAKE 3'h7

`endif

// File: dprc_ctrl.sv
// Holds the top of the port controller for one side of a dual-port RAM.
// Assumes an APB master on the register side and one device port on the pin side.
`timescale 1ns/1ns
`default_nettype none
`include "dprc_consts.svh"

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Flag space is used with array select high and flag select low.
// - Hold address and select long enough for busy before the write strobe.
// - Use only one master per width-expanded array.
// - Depth expansion forms the array busy as the AND of device busies.
// - Slave busy held high for normal writes, low to block all writes; flag writes here still go ahead.
module dprc_ctrl #(
	parameter bit IS_LEFT_PORT = 1'b1,
	parameter int N_BUSY = 1
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device port pins.
	output logic [13:0] mem_addr,
	output logic array_sel_n,
	output logic flag_space_select_n,
	output logic out_gate_n,
	output logic write_strobe_n,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] dq_in,
	// Busy, role and mailbox pins.
	input wire logic [N_BUSY-1:0] busy_in_n,
	output logic busy_out_n,
	output logic busy_oe,
	output logic arbiter_role,
	input wire logic own_mailbox_irq_n
);

	// Mailbox this side reads and mailbox of the far side it writes.
	localparam logic [13:0] OWN_BOX = IS_LEFT_PORT ? `DPRC_MBOX_LEFT : `DPRC_MBOX_RIGHT;
	localparam logic [13:0] PEER_BOX = IS_LEFT_PORT ? `DPRC_MBOX_RIGHT : `DPRC_MBOX_LEFT;

	dprc_pkg::dprc_tstate_e tstate;
	dprc_pkg::dprc_req_s req;
	dprc_pkg::dprc_pins_s pins;
	logic [2:0] cmd;
	logic acq_step;
	logic [2:0] init_idx;
	logic [13:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] seq_rdata;
	logic [7:0] rdata_reg;
	logic st_done;
	logic st_busy_seen;
	logic st_owned;
	logic st_refused;
	logic init_done;
	logic cfg_master;
	logic cfg_block;
	logic seq_idle;
	logic seq_done;
	logic seq_busy_seen;
	logic busy_ok;
	logic wr_access;
	logic rd_setup;
	logic mapped;
	logic go;
	logic [2:0] wr_cmd;
	logic [7:0] status;

	////////////////////////////////////////////////////////////////////////////
	// APB decode: zero wait states, error on unmapped offsets.

	assign pready = 1'b1;
	assign mapped = (paddr == `DPRC_REG_CTRL) || (paddr == `DPRC_REG_ADDR) ||
		(paddr == `DPRC_REG_WDATA) || (paddr == `DPRC_REG_RDATA) ||
		(paddr == `DPRC_REG_STATUS) || (paddr == `DPRC_REG_CFG);
	assign pslverr = psel && penable && !mapped;
	assign wr_access = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_cmd = pwdata[`DPRC_CTRL_CMD_MSB:`DPRC_CTRL_CMD_LSB];
	assign go = wr_access && (paddr == `DPRC_REG_CTRL) && pwdata[`DPRC_CTRL_GO];

	// Status word gathers controller and pin state.
	always_comb begin
		status = 8'h00;
		status[`DPRC_ST_ACTIVE] = (tstate != dprc_pkg::T_IDLE) || !seq_idle;
		status[`DPRC_ST_DONE] = st_done;
		status[`DPRC_ST_BUSY_SEEN] = st_busy_seen;
		status[`DPRC_ST_MBOX] = ~own_mailbox_irq_n;
		status[`DPRC_ST_OWNED] = st_owned;
		status[`DPRC_ST_INIT_DONE] = init_done;
		status[`DPRC_ST_BUSY_OK] = busy_ok;
		status[`DPRC_ST_REFUSED] = st_refused;
	end

	// Read data is captured in the setup phase and stands through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (paddr)
				`DPRC_REG_CTRL: prdata <= {28'h000_0000, cmd, 1'b0};
				`DPRC_REG_ADDR: prdata <= {18'h0_0000, addr_reg};
				`DPRC_REG_WDATA: prdata <= {24'h00_0000, wdata_reg};
				`DPRC_REG_RDATA: prdata <= {24'h00_0000, rdata_reg};
				`DPRC_REG_STATUS: prdata <= {24'h00_0000, status};
				`DPRC_REG_CFG: prdata <= {30'h0000_0000, cfg_block, cfg_master};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Address, write data and configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= 14'h0000;
			wdata_reg <= 8'h00;
			cfg_master <= 1'b0;
			cfg_block <= 1'b0;
		end else if (wr_access) begin
			if (paddr == `DPRC_REG_ADDR) begin
				addr_reg <= pwdata[13:0];
			end
			if (paddr == `DPRC_REG_WDATA) begin
				wdata_reg <= pwdata[7:0];
			end
			if (paddr == `DPRC_REG_CFG) begin
				cfg_master <= pwdata[`DPRC_CFG_MASTER];
				cfg_block <= pwdata[`DPRC_CFG_BLOCK];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command engine.

	// Walks the start-up release of all flags, then runs commands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tstate <= dprc_pkg::T_INIT;
			req <= '{op: dprc_pkg::OP_SEM_WR, addr: 14'h0000, wdata: `DPRC_SEM_FREE};
			cmd <= `DPRC_CMD_MEM_RD;
			acq_step <= 1'b0;
			init_idx <= 3'h0;
			init_done <= 1'b0;
		end else begin
			unique case (tstate)
				dprc_pkg::T_INIT: begin
					// Write one to every flag so no stale request latch remains.
					req <= '{op: dprc_pkg::OP_SEM_WR, addr: {11'h000, init_idx},
						wdata: `DPRC_SEM_FREE};
					tstate <= dprc_pkg::T_ISSUE;
				end
				dprc_pkg::T_IDLE: begin
					if (go) begin
						cmd <= wr_cmd;
						acq_step <= 1'b0;
						tstate <= dprc_pkg::T_ISSUE;
						unique case (wr_cmd)
							`DPRC_CMD_MEM_RD: req <= '{dprc_pkg::OP_MEM_RD, addr_reg, wdata_reg};
							`DPRC_CMD_MEM_WR: req <= '{dprc_pkg::OP_MEM_WR, addr_reg, wdata_reg};
							`DPRC_CMD_SEM_RD: req <= '{dprc_pkg::OP_SEM_RD, addr_reg, wdata_reg};
							`DPRC_CMD_SEM_WR: req <= '{dprc_pkg::OP_SEM_WR, addr_reg, wdata_reg};
							// Acquire writes zero first, then reads back.
							`DPRC_CMD_SEM_ACQ: req <= '{dprc_pkg::OP_SEM_WR, addr_reg,
								`DPRC_SEM_TAKE};
							`DPRC_CMD_SEM_REL: req <= '{dprc_pkg::OP_SEM_WR, addr_reg,
								`DPRC_SEM_FREE};
							`DPRC_CMD_MBOX_SEND: req <= '{dprc_pkg::OP_MEM_WR, PEER_BOX,
								wdata_reg};
							`DPRC_CMD_MBOX_TAKE: req <= '{dprc_pkg::OP_MEM_RD, OWN_BOX,
								wdata_reg};
						endcase
					end
				end
				dprc_pkg::T_ISSUE: begin
					tstate <= dprc_pkg::T_WAIT;
				end
				dprc_pkg::T_WAIT: begin
					if (seq_done) begin
						if (!init_done) begin
							if (init_idx == `DPRC_SEM_LAST) begin
								init_done <= 1'b1;
								tstate <= dprc_pkg::T_IDLE;
							end else begin
								init_idx <= init_idx + 3'h1;
								tstate <= dprc_pkg::T_INIT;
							end
						end else if (cmd == `DPRC_CMD_SEM_ACQ && !acq_step) begin
							// Write then read, never the other way round.
							acq_step <= 1'b1;
							req.op <= dprc_pkg::OP_SEM_RD;
							tstate <= dprc_pkg::T_ISSUE;
						end else begin
							tstate <= dprc_pkg::T_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Completion flags and captured read data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_done <= 1'b0;
			st_busy_seen <= 1'b0;
			st_owned <= 1'b0;
			st_refused <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			if (go && tstate == dprc_pkg::T_IDLE) begin
				st_done <= 1'b0;
				st_busy_seen <= 1'b0;
				st_refused <= 1'b0;
			end else if (go) begin
				st_refused <= 1'b1;
			end
			if (seq_done && init_done) begin
				st_busy_seen <= st_busy_seen | seq_busy_seen;
				if (req.op == dprc_pkg::OP_SEM_RD || req.op == dprc_pkg::OP_MEM_RD) begin
					rdata_reg <= seq_rdata;
				end
				// A flag read as all zeros means this side holds the token.
				if (req.op == dprc_pkg::OP_SEM_RD) begin
					st_owned <= (seq_rdata == `DPRC_SEM_TAKE);
				end
				if (!(cmd == `DPRC_CMD_SEM_ACQ && !acq_step)) begin
					st_done <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer, busy handling and pin fan-out.

	dprc_pin_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.start(tstate == dprc_pkg::T_ISSUE),
		.req(req),
		.idle(seq_idle),
		.done(seq_done),
		.rdata(seq_rdata),
		.busy_seen(seq_busy_seen),
		.busy_ok(busy_ok),
		.dq_in(dq_in),
		.pins(pins)
	);

	dprc_busy_ctl #(.N_BUSY(N_BUSY)) u_busy (
		.master_role(cfg_master),
		.block_writes(cfg_block),
		.busy_in_n(busy_in_n),
		.busy_out_n(busy_out_n),
		.busy_oe(busy_oe),
		.arbiter_role(arbiter_role),
		.busy_ok(busy_ok)
	);

	// Pin outputs come straight from the sequencer flip-flops.
	assign mem_addr = pins.addr;
	assign array_sel_n = pins.array_sel_n;
	assign flag_space_select_n = pins.flag_space_select_n;
	assign out_gate_n = pins.out_gate_n;
	assign write_strobe_n = pins.write_strobe_n;
	assign dq_out = pins.dq_out;
	assign dq_oe = pins.dq_oe;

endmodule
`default_nettype wire

// File: dprc_ctrl_assertions.sv
// Checker of the controlled port pins of dprc_ctrl.
// Assumes it is bound to dprc_ctrl and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module dprc_ctrl_chk #(
	parameter int N_BUSY = 1
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Watched pins.
	input wire logic [13:0] mem_addr,
	input wire logic array_sel_n,
	input wire logic flag_space_select_n,
	input wire logic out_gate_n,
	input wire logic write_strobe_n,
	input wire logic dq_oe,
	input wire logic [N_BUSY-1:0] busy_in_n,
	input wire logic busy_oe,
	input wire logic arbiter_role
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Pin relations that every cycle must keep.
	property p_one_space; !(!array_sel_n && !flag_space_select_n); endproperty
	a_one_space: assert property (p_one_space) else $error("both selects low");
	property p_strobe_oe; !write_strobe_n |-> dq_oe && (array_sel_n != flag_space_select_n);
	endproperty
	a_strobe_oe: assert property (p_strobe_oe) else $error("strobe without data");
	property p_strobe_len; $fell(write_strobe_n) |-> !write_strobe_n[*5] ##1 write_strobe_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
	property p_gate_len; $fell(out_gate_n) |-> !out_gate_n[*7] ##1 out_gate_n; endproperty
	a_gate_len: assert property (p_gate_len) else $error("gate length");
	property p_role; arbiter_role != busy_oe; endproperty
	a_role: assert property (p_role) else $error("busy direction");
	property p_busy_hold;
		!array_sel_n && arbiter_role && !(&busy_in_n) && write_strobe_n |=> write_strobe_n;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("strobe during busy");
	property p_flag_addr; !flag_space_select_n |-> mem_addr[13:3] == 11'h000; endproperty
	a_flag_addr: assert property (p_flag_addr) else $error("flag address");
	property p_standby;
		array_sel_n && flag_space_select_n |-> !dq_oe && write_strobe_n && out_gate_n;
	endproperty
	a_standby: assert property (p_standby) else $error("access in standby");

	// Main scenarios.
	c_flag_wr: cover property (!write_strobe_n && !flag_space_select_n);
	c_busy_wait: cover property (!array_sel_n && !(&busy_in_n));
	c_mem_rd: cover property (!out_gate_n && !array_sel_n);
endmodule

bind dprc_ctrl dprc_ctrl_chk #(.N_BUSY(N_BUSY)) dprc_ctrl_chk_inst (
	.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr), .array_sel_n(array_sel_n),
	.flag_space_select_n(flag_space_select_n), .out_gate_n(out_gate_n),
	.write_strobe_n(write_strobe_n), .dq_oe(dq_oe), .busy_in_n(busy_in_n),
	.busy_oe(busy_oe), .arbiter_role(arbiter_role)
);
`default_nettype wire

// File: dprc_ctrl_bench.sv
// Self-checking bench of dprc_ctrl against the device model.
// Assumes the controller drives the left port of the model.
`timescale 1ns/1ns
`default_nettype none
module dprc_ctrl_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic [7:0] paddr, dq_out, dq_in, d;
	logic [31:0] pwdata, prdata, q;
	logic [13:0] mem_addr, a;
	logic array_sel_n, flag_space_select_n, out_gate_n, write_strobe_n, dq_oe;
	logic busy_in_n, busy_out_n, busy_oe, arbiter_role, irq_n;
	int err_total = 0;
	int tests_run = 0;
	int seed = 87;
	int exp_mem [int];
	logic [13:0] qa [$];
	logic [9:0] t_side = 10'h32d; // Step is made by the left port.
	logic [9:0] t_val = 10'h2b4;
	logic [9:0] t_own = 10'h113; // Left port reads zero after the step.

	////////////////////////////////////////////////////////////////////////////////
	dprc_ctrl #(.IS_LEFT_PORT(1'b1), .N_BUSY(1)) dprc_ctrl_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
		.array_sel_n(array_sel_n), .flag_space_select_n(flag_space_select_n),
		.out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in), .busy_in_n(busy_in_n), .busy_out_n(busy_out_n), .busy_oe(busy_oe),
		.arbiter_role(arbiter_role), .own_mailbox_irq_n(irq_n));
	dprc_dev_model dprc_dev_model_inst (.mem_addr(mem_addr), .array_sel_n(array_sel_n),
		.flag_space_select_n(flag_space_select_n), .out_gate_n(out_gate_n),
		.write_strobe_n(write_strobe_n), .dq_out(dq_out), .dq_in(dq_in), .busy_out_n(busy_out_n),
		.busy_oe(busy_oe), .arbiter_role(arbiter_role), .busy_in_n(busy_in_n),
		.left_mailbox_irq_n(irq_n));

	// Free-running clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Comparison and verdict.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// One APB transfer; read data lands in q, the error answer in slv.
	task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		paddr <= ad;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		if (n >= 50) test_done();
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Polls one status bit under a bound.
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		q = 32'h0000_0000;
		while (q[b] !== 1'b1) begin
			apb(8'h10, 1'b0, 32'h0000_0000);
			n++;
			if (n > 300) err_total++;
			if (n > 300) test_done();
		end
	endtask
	task automatic run(input logic [2:0] c);
		apb(8'h00, 1'b1, 32'({c, 1'b1}));
		wait_bit(1);
	endtask
	task automatic flag_read(input logic [7:0] e);
		run(3'h2);
		apb(8'h0c, 1'b0, 32'h0000_0000);
		chk(q, 32'(e));
	endtask

	// Main sequence.
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge pclk);
		chk(32'({array_sel_n, flag_space_select_n, out_gate_n, write_strobe_n, dq_oe, busy_oe,
			busy_out_n, arbiter_role}), 32'h0000_00f6);
		presetn <= 1'b1;
		@(posedge pclk);
		wait_bit(5);
		for (int k = 0; k < 8; k++) begin
			apb(8'h04, 1'b1, 32'(k));
			flag_read(8'hff);
			for (int s = 0; s < 10; s++) begin
				if (t_side[s]) begin
					apb(8'h08, 1'b1, ($random(seed) & 32'hffff_fffe) | 32'(t_val[s]));
					run(3'h3);
				end else begin
					dprc_dev_model_inst.sem_write(1'b0, k, t_val[s]);
				end
				flag_read(t_own[s] ? 8'h00 : 8'hff);
			end
			run(3'h4);
			chk(32'(q[4]), 32'h0000_0001);
			dprc_dev_model_inst.sem_write(1'b0, k, 1'b0);
			run(3'h5);
			flag_read(8'hff);
			dprc_dev_model_inst.sem_write(1'b0, k, 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			a = 14'($random(seed)) & 14'h3ff0;
			d = 8'($random(seed));
			exp_mem[a] = d;
			qa.push_back(a);
			apb(8'h04, 1'b1, 32'(a));
			apb(8'h08, 1'b1, ($random(seed) & 32'hffff_ff00) | 32'(d));
			run(3'h1);
		end
		foreach (qa[i]) begin
			apb(8'h04, 1'b1, 32'(qa[i]));
			run(3'h0);
			apb(8'h0c, 1'b0, 32'h0000_0000);
			chk(q, 32'(exp_mem[qa[i]]));
		end
		dprc_dev_model_inst.right_write(14'h3ffe, 8'ha5);
		apb(8'h10, 1'b0, 32'h0000_0000);
		chk(32'(q[3]), 32'h0000_0001);
		run(3'h7);
		apb(8'h0c, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_00a5);
		chk(32'(irq_n), 32'h0000_0001);
		apb(8'h08, 1'b1, 32'h0000_003c);
		run(3'h6);
		chk(32'(dprc_dev_model_inst.mem[16383]), 32'h0000_003c);
		chk(32'(dprc_dev_model_inst.right_irq_n), 32'h0000_0000);
		dprc_dev_model_inst.right_take();
		apb(8'h14, 1'b1, 32'h0000_0001);
		chk(32'({arbiter_role, busy_oe}), 32'h0000_0002);
		dprc_dev_model_inst.right_write(14'h0100, 8'h11);
		dprc_dev_model_inst.right_addr <= 14'h0100;
		dprc_dev_model_inst.right_hold <= 1'b1;
		apb(8'h04, 1'b1, 32'h0000_0100);
		apb(8'h08, 1'b1, 32'h0000_0077);
		apb(8'h00, 1'b1, 32'h0000_0003);
		repeat (6) apb(8'h10, 1'b0, 32'h0000_0000);
		chk(32'({q[6], q[0]}), 32'h0000_0001);
		chk(32'(dprc_dev_model_inst.mem[256]), 32'h0000_0011);
		apb(8'h00, 1'b1, 32'h0000_0001);
		apb(8'h10, 1'b0, 32'h0000_0000);
		chk(32'(q[7]), 32'h0000_0001);
		dprc_dev_model_inst.right_hold <= 1'b0;
		wait_bit(1);
		chk(32'(dprc_dev_model_inst.mem[256]), 32'h0000_0077);
		apb(8'h14, 1'b1, 32'h0000_0002);
		chk(32'({busy_oe, busy_out_n, arbiter_role}), 32'h0000_0004);
		apb(8'h08, 1'b1, 32'h0000_005a);
		apb(8'h00, 1'b1, 32'h0000_0003);
		repeat (4) apb(8'h10, 1'b0, 32'h0000_0000);
		chk(32'({q[6], q[0]}), 32'h0000_0001);
		chk(32'(dprc_dev_model_inst.mem[256]), 32'h0000_0077);
		apb(8'h14, 1'b1, 32'h0000_0000);
		chk(32'({busy_oe, busy_out_n}), 32'h0000_0003);
		wait_bit(1);
		chk(32'(dprc_dev_model_inst.mem[256]), 32'h0000_005a);
		apb(8'h20, 1'b0, 32'h0000_0000);
		chk({q[30:0], slv}, 32'h0000_0001);
		test_done();
	end
endmodule
`default_nettype wire

// File: dprc_dev_model.sv
// Behavioural dual-port RAM seen from its left port; the right port is driven by tasks.
// Assumes the controller under test is on the left port.
`timescale 1ns/1ns
`default_nettype none
module dprc_dev_model (
	// Left port pins.
	input wire logic [13:0] mem_addr,
	input wire logic array_sel_n,
	input wire logic flag_space_select_n,
	input wire logic out_gate_n,
	input wire logic write_strobe_n,
	input wire logic [7:0] dq_out,
	output logic [7:0] dq_in,
	// Busy, role and mailbox pins.
	input wire logic busy_out_n,
	input wire logic busy_oe,
	input wire logic arbiter_role,
	output logic busy_in_n,
	output logic left_mailbox_irq_n
);
	logic [7:0] mem [0:16383];
	logic [7:0] req_l = 8'h00; // Stale requests left from power-up.
	logic [7:0] req_r = 8'hff;
	int holder [8] = '{default: 1};
	logic [7:0] latch = 8'hff;
	logic [7:0] last = 8'h00;
	logic right_hold = 1'b0;
	logic [13:0] right_addr = 14'h0000;
	logic right_irq_n = 1'b1;
	wire blocked;

	////////////////////////////////////////////////////////////////////////////////
	// Request latches feed the flag; a release hands over to a pending request.
	task automatic sem_write(input bit left, input int i, input bit v);
		if (left) req_l[i] = v; else req_r[i] = v;
		if (holder[i] == 1 && req_l[i]) holder[i] = req_r[i] ? 0 : 2;
		if (holder[i] == 2 && req_r[i]) holder[i] = req_l[i] ? 0 : 1;
		if (holder[i] == 0) holder[i] = !req_l[i] ? 1 : (!req_r[i] ? 2 : 0);
	endtask

	// Right port accesses.
	task automatic right_write(input logic [13:0] a, input logic [7:0] d);
		mem[a] = d;
		if (a == 14'h3ffe) left_mailbox_irq_n = 1'b0;
	endtask
	task automatic right_take();
		right_irq_n = 1'b1;
	endtask

	// The right port holds the location first, so the left side sees busy.
	// One device stands alone here, so its pin is already the array busy.
	assign busy_in_n = !(arbiter_role && right_hold && !array_sel_n &&
		mem_addr == right_addr);
	assign blocked = arbiter_role ? !busy_in_n : (busy_oe && !busy_out_n);

	// Writes land at the end of the strobe; flag writes never wait.
	always @(posedge write_strobe_n) begin
		if (!array_sel_n && !blocked) begin
			mem[mem_addr] = dq_out;
			if (mem_addr == 14'h3fff) right_irq_n = 1'b0;
		end else if (!flag_space_select_n) begin
			sem_write(1'b1, mem_addr[2:0], dq_out[0]);
		end
	end

	// Flag value is frozen for the whole read; a mailbox read clears the interrupt.
	always @(negedge (flag_space_select_n | out_gate_n)) begin
		latch = holder[mem_addr[2:0]] == 1 ? 8'h00 : 8'hff;
	end
	always @(negedge (array_sel_n | out_gate_n)) begin
		if (mem_addr == 14'h3ffe) left_mailbox_irq_n = 1'b1;
	end
	// The released value is taken from its source, not from the lines it feeds.
	always @(posedge out_gate_n) begin
		last = !array_sel_n ? ~mem[mem_addr] : ~latch;
	end
	initial left_mailbox_irq_n = 1'b1;

	// Data lines carry the inverse of the last value when not read.
	always @* begin
		if (!out_gate_n && !array_sel_n) dq_in = mem[mem_addr];
		else if (!out_gate_n && !flag_space_select_n) dq_in = latch;
		else dq_in = last;
	end
endmodule
`default_nettype wire

// File: dprc_pin_seq.sv
// Holds the pin sequencer that runs one read or write cycle on a device port.
// Assumes the device answers within the fixed read time and that busy_ok is clean.
`timescale 1ns/1ns
`default_nettype none
`include "dprc_consts.svh"
module dprc_pin_seq (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Request side.
	input wire logic start,
	input wire dprc_pkg::dprc_req_s req,
	output logic idle,
	output logic done,
	output logic [7:0] rdata,
	output logic busy_seen,
	// Device side.
	input wire logic busy_ok,
	input wire logic [7:0] dq_in,
	output dprc_pkg::dprc_pins_s pins
);

	localparam logic [3:0] SETTLE_CYC = 4'(`DPRC_CYC(`DPRC_T_SETTLE_NS));
	localparam logic [3:0] WRITE_CYC = 4'(`DPRC_CYC(`DPRC_T_WRITE_NS));
	localparam logic [3:0] READ_CYC = 4'(`DPRC_CYC(`DPRC_T_READ_NS));
	localparam logic [3:0] RECOVER_CYC = 4'(`DPRC_CYC(`DPRC_T_RECOVER_NS));

	dprc_pkg::dprc_sstate_e state;
	logic [3:0] cnt;
	logic is_write;
	logic is_sem;

	assign idle = (state == dprc_pkg::S_IDLE);
	assign is_write = (req.op == dprc_pkg::OP_MEM_WR) || (req.op == dprc_pkg::OP_SEM_WR);
	assign is_sem = (req.op == dprc_pkg::OP_SEM_RD) || (req.op == dprc_pkg::OP_SEM_WR);

	// One cycle walks select, settle, busy wait (writes only), strobe or gate, deselect.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= dprc_pkg::S_IDLE;
			cnt <= 4'h0;
			done <= 1'b0;
			rdata <= 8'h00;
			busy_seen <= 1'b0;
			pins <= '{addr: 14'h0000, array_sel_n: 1'b1, flag_space_select_n: 1'b1,
				out_gate_n: 1'b1, write_strobe_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
		end else begin
			done <= 1'b0;
			unique case (state)
				dprc_pkg::S_IDLE: begin
					if (start) begin
						// Semaphore space: array select high, flag select low.
						pins.addr <= is_sem ? {11'h000, req.addr[2:0]} : req.addr;
						pins.array_sel_n <= is_sem;
						pins.flag_space_select_n <= ~is_sem;
						pins.dq_out <= req.wdata;
						busy_seen <= 1'b0;
						cnt <= SETTLE_CYC;
						state <= dprc_pkg::S_SETUP;
					end
				end
				dprc_pkg::S_SETUP: begin
					// Address and select settle so a master busy decision shows first.
					if (cnt > 4'h1) begin
						cnt <= cnt - 4'h1;
					end else if (is_write) begin
						state <= dprc_pkg::S_WAIT_BUSY;
					end else begin
						if (!busy_ok) begin
							busy_seen <= 1'b1;
						end
						pins.out_gate_n <= 1'b0;
						cnt <= READ_CYC;
						state <= dprc_pkg::S_READ;
					end
				end
				dprc_pkg::S_WAIT_BUSY: begin
					// A memory write is held off while this port sees busy; a flag write goes ahead.
					if (busy_ok || is_sem) begin
						pins.write_strobe_n <= 1'b0;
						pins.dq_oe <= 1'b1;
						cnt <= WRITE_CYC;
						state <= dprc_pkg::S_STROBE;
					end else begin
						busy_seen <= 1'b1;
					end
				end
				dprc_pkg::S_STROBE: begin
					if (cnt > 4'h1) begin
						cnt <= cnt - 4'h1;
					end else begin
						pins.write_strobe_n <= 1'b1;
						cnt <= RECOVER_CYC;
						state <= dprc_pkg::S_RECOVER;
					end
				end
				dprc_pkg::S_READ: begin
					if (cnt > 4'h1) begin
						cnt <= cnt - 4'h1;
					end else begin
						rdata <= dq_in;
						pins.out_gate_n <= 1'b1;
						cnt <= RECOVER_CYC;
						state <= dprc_pkg::S_RECOVER;
					end
				end
				dprc_pkg::S_RECOVER: begin
					// Both selects high: standby, and the flag read latch reopens.
					pins.array_sel_n <= 1'b1;
					pins.flag_space_select_n <= 1'b1;
					pins.dq_oe <= 1'b0;
					if (cnt > 4'h1) begin
						cnt <= cnt - 4'h1;
					end else begin
						done <= 1'b1;
						state <= dprc_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// File: dprc_pkg.sv
// Holds the types shared by the dual-port RAM port controller.
// Assumes nothing of its surroundings.
package dprc_pkg;

	// Kinds of single pin cycle.
	typedef enum logic [1:0] {OP_MEM_RD, OP_MEM_WR, OP_SEM_RD, OP_SEM_WR} dprc_op_e;

	// Pin sequencer states.
	typedef enum logic [2:0] {
		S_IDLE, S_SETUP, S_WAIT_BUSY, S_STROBE, S_READ, S_RECOVER
	} dprc_sstate_e;

	// Command engine states.
	typedef enum logic [2:0] {T_INIT, T_IDLE, T_ISSUE, T_WAIT} dprc_tstate_e;

	// One request to the pin sequencer.
	typedef struct packed {
		dprc_op_e op;
		logic [13:0] addr;
		logic [7:0] wdata;
	} dprc_req_s;

	// Control pins of one device port.
	typedef struct packed {
		logic [13:0] addr;
		logic array_sel_n;
		logic flag_space_select_n;
		logic out_gate_n;
		logic write_strobe_n;
		logic [7:0] dq_out;
		logic dq_oe;
	} dprc_pins_s;

endpackage
